// ### core/dee_ctrl.sv
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Operation
// RULE1 - Software loads both index registers, clears space_select and then sets read_start.
// RULE2 - The addressed byte lands in nv_byte_buffer one cycle after the read starts.
// RULE3 - nv_byte_buffer keeps a fetched byte until the next read or a software write to it.
// RULE4 - A byte write starts only after 55h then 0AAh to the key port, then program-go.
// RULE5 - Setting program-go is ignored while program_permit is clear.
// RULE6 - Hardware never clears program_permit; only software writes change it.
// RULE7 - While a write runs, control, both index registers and the buffer are frozen.
// RULE8 - program_permit must already be set; setting it with program-go starts nothing.
// RULE9 - When the write completes, program-go clears and nv_done_flag is set.
// RULE10 - Software clears nv_done_flag itself, whether it polls or takes the interrupt.
// RULE11 - Software should mask interrupts across the key and program-go sequence.
// RULE12 - Software should keep program_permit clear except while updating the array.
// RULE13 - read_start clears itself once the fetched byte is in nv_byte_buffer.
module dee_ctrl
    import dee_pkg::*;
#(
    parameter int WRITE_CYCLES = DEE_WRITE_CYCLES  // Length of one byte write
)
(
    input  wire logic        hclk,      // Bus clock, 40 MHz
    input  wire logic        hresetn,   // Async reset, active low
    input  wire logic        hsel,      // AHB select
    input  wire logic [31:0] haddr,     // AHB address
    input  wire logic [1:0]  htrans,    // AHB transfer type
    input  wire logic        hwrite,    // AHB write
    input  wire logic [2:0]  hsize,     // AHB size
    input  wire logic [31:0] hwdata,    // AHB write data
    input  wire logic        hready,    // AHB ready in
    output logic             hreadyout, // AHB ready out
    output logic             hresp,     // AHB response
    output logic      [31:0] hrdata,    // AHB read data
    output logic             irq        // Level interrupt, done and unmasked
);

    // Whole state of the controller, registered on every edge
    typedef struct packed {
        logic [7:0]            index_low;
        logic [DEE_HIGH_W-1:0] index_high;
        logic [7:0]            buffer;
        logic                  space_select;
        logic                  program_permit;
        logic                  program_go;
        logic                  read_start;
        dee_key_t              key;
        logic [DEE_WAIT_W-1:0] wait_count;
        logic                  nv_done_flag;
        logic                  done_mask;
    } dee_state_t;

    // Timer load; program_go stands for exactly WRITE_CYCLES cycles
    // A length of zero would wrap the timer, so WRITE_CYCLES must be one or more
    localparam logic [DEE_WAIT_W-1:0] WAIT_LOAD = DEE_WAIT_W'(WRITE_CYCLES - 1);

    // Software edits to the write set are shut out while a byte write runs
    // Key port, status and mask stay open so software can poll and clear
    function automatic logic edits_open(input dee_state_t cur);
        edits_open = !cur.program_go;
    endfunction : edits_open

    // Unlock sequence; a first key always restarts it, any stray value drops it
    // Reads and unmapped writes leave it alone; other register writes drop it in the next-state logic
    function automatic dee_key_t key_step(input dee_key_t cur, input logic [7:0] data);
        key_step = KEY_IDLE;
        case (cur)
            KEY_IDLE, KEY_ARMED:
            begin
                if (data == DEE_KEY_FIRST)
                begin
                    key_step = KEY_GOT_FIRST;
                end
            end
            KEY_GOT_FIRST:
            begin
                if (data == DEE_KEY_FIRST)
                begin
                    key_step = KEY_GOT_FIRST;
                end
                else if (data == DEE_KEY_SECOND)
                begin
                    key_step = KEY_ARMED;  // see RULE4
                end
            end
            default:
            begin
                key_step = KEY_IDLE;
            end
        endcase
    endfunction : key_step

    dee_state_t            s;
    dee_state_t            next_s;
    dee_wr_t               wr;
    logic [7:0]            rd_addr;
    logic [31:0]           rd_data;
    logic                  mem_we;
    logic [7:0]            mem_rdata;
    logic [DEE_IDX_W-1:0]  mem_addr;
    logic [7:0]            ctl_byte;
    logic                  wr_go;
    logic                  wr_read;
    logic                  wr_space;
    logic                  go_ok;
    logic                  read_ok;

    // Bus slave
    dee_ahb u_ahb (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr        (wr),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data)
    );

    // The array always addresses the index pair; it is frozen during a write
    assign mem_addr = {s.index_high, s.index_low};

    // Array contents survive reset; a byte never written reads back unknown
    dee_mem u_mem (
        .hclk  (hclk),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata (s.buffer),
        .rdata (mem_rdata)
    );

    // Fields of an incoming control write
    assign wr_go    = wr.wdata[DEE_CTL_GO_BIT];
    assign wr_read  = wr.wdata[DEE_CTL_READ_BIT];
    assign wr_space = wr.wdata[DEE_CTL_SPACE_BIT];

    // Go is judged on the old permit, so permit and go in one write start nothing
    assign go_ok   = wr_go && s.program_permit && (s.key == KEY_ARMED) && !wr_space;
    // A read of program space, or one mixed with go, has nothing to fetch
    assign read_ok = wr_read && !wr_go && !wr_space;

    // Control register as software sees it
    always_comb
    begin
        ctl_byte                     = 8'h00;
        ctl_byte[DEE_CTL_SPACE_BIT]  = s.space_select;
        ctl_byte[DEE_CTL_PERMIT_BIT] = s.program_permit;
        ctl_byte[DEE_CTL_GO_BIT]     = s.program_go;
        ctl_byte[DEE_CTL_READ_BIT]   = s.read_start;
    end

    // Read-back mux; the key port has no storage and reads as zero
    // Unused bits read as zero so software may test whole words
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (rd_addr)
            DEE_OFF_INDEX_LOW:  rd_data[7:0] = s.index_low;
            DEE_OFF_INDEX_HIGH: rd_data[DEE_HIGH_W-1:0] = s.index_high;
            DEE_OFF_BUFFER:     rd_data[7:0] = s.buffer;
            DEE_OFF_CONTROL:    rd_data[7:0] = ctl_byte;
            DEE_OFF_STATUS:     rd_data[DEE_STA_DONE_BIT] = s.nv_done_flag;
            DEE_OFF_MASK:       rd_data[DEE_STA_DONE_BIT] = s.done_mask;
            default:            rd_data = 32'h0000_0000;
        endcase
    end

    // Next state: bus writes, then the write timer so that a set beats a clear
    // The fetch capture comes before bus writes, so a buffer write in that cycle wins
    always_comb
    begin
        next_s = s;
        mem_we = 1'b0;

        // The array registered the index last edge; capture it now
        // read_start drops with the capture, so it reads high for one cycle only
        if (s.read_start)
        begin
            next_s.buffer     = mem_rdata;  // see RULE2
            next_s.read_start = 1'b0;       // see RULE13
        end

        if (wr.valid)
        begin
            // Any mapped write other than to the key port breaks the unlock sequence
            // Key port writes are never frozen, but keys sent early are dropped by the next index or buffer write
            if (wr.addr != DEE_OFF_KEY_PORT)
            begin
                next_s.key = KEY_IDLE;      // see RULE4
            end
            case (wr.addr)
                DEE_OFF_INDEX_LOW:
                begin
                    if (edits_open(s))      // see RULE7
                    begin
                        next_s.index_low = wr.wdata[7:0];
                    end
                end
                DEE_OFF_INDEX_HIGH:
                begin
                    if (edits_open(s))      // see RULE7
                    begin
                        next_s.index_high = wr.wdata[DEE_HIGH_W-1:0];
                    end
                end
                DEE_OFF_BUFFER:
                begin
                    // A software write replaces a fetched byte
                    if (edits_open(s))      // see RULE7
                    begin
                        next_s.buffer = wr.wdata[7:0];  // see RULE3
                    end
                end
                DEE_OFF_CONTROL:
                begin
                    if (edits_open(s))      // see RULE7
                    begin
                        next_s.space_select   = wr_space;
                        next_s.program_permit = wr.wdata[DEE_CTL_PERMIT_BIT];  // see RULE6
                        // Permit is judged on its old value, so setting both starts no write
                        if (go_ok)
                        begin
                            next_s.program_go = 1'b1;  // see RULE4, see RULE5, see RULE8
                            next_s.wait_count = WAIT_LOAD;
                        end
                        else if (read_ok)
                        begin
                            next_s.read_start = 1'b1;  // see RULE1
                        end
                    end
                end
                DEE_OFF_KEY_PORT:
                begin
                    next_s.key = key_step(s.key, wr.wdata[7:0]);  // see RULE4
                end
                DEE_OFF_STATUS:
                begin
                    // Write one to clear; hardware never clears it
                    if (wr.wdata[DEE_STA_DONE_BIT])
                    begin
                        next_s.nv_done_flag = 1'b0;  // see RULE10
                    end
                end
                DEE_OFF_MASK:
                begin
                    next_s.done_mask = wr.wdata[DEE_STA_DONE_BIT];
                end
                default:
                begin
                    next_s.key = KEY_IDLE;
                end
            endcase
        end

        // Write cycle timer; the byte lands in the array as the cycle ends
        // Permit is left alone here; only software takes it away again
        if (s.program_go)
        begin
            if (s.wait_count == '0)
            begin
                mem_we              = 1'b1;
                next_s.program_go   = 1'b0;  // see RULE9
                next_s.nv_done_flag = 1'b1;  // see RULE9
            end
            else
            begin
                next_s.wait_count = s.wait_count - 1'b1;
            end
        end
    end

    // Reset returns the unlock sequence to idle, so a half-entered key pair
    // cannot arm a write for the software that runs after it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s              <= '0;
            s.index_low    <= DEE_RST_BYTE;
            s.buffer       <= DEE_RST_BYTE;
            s.key          <= KEY_IDLE;
            s.done_mask    <= DEE_RST_BIT;
            s.nv_done_flag <= DEE_RST_BIT;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Interrupt is a plain level; software owns the flag
    // A masked flag stays set, so unmasking later raises the line at once
    assign irq = s.nv_done_flag && s.done_mask;

endmodule : dee_ctrl

// ### core/dee_pkg.sv
package dee_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] DEE_OFF_INDEX_LOW  = 8'h00;
    localparam logic [7:0] DEE_OFF_INDEX_HIGH = 8'h04;
    localparam logic [7:0] DEE_OFF_BUFFER     = 8'h08;
    localparam logic [7:0] DEE_OFF_CONTROL    = 8'h0c;
    localparam logic [7:0] DEE_OFF_KEY_PORT   = 8'h10;
    localparam logic [7:0] DEE_OFF_STATUS     = 8'h14;
    localparam logic [7:0] DEE_OFF_MASK       = 8'h18;

    // Field positions
    localparam int DEE_CTL_SPACE_BIT  = 7;
    localparam int DEE_CTL_PERMIT_BIT = 2;
    localparam int DEE_CTL_GO_BIT     = 1;
    localparam int DEE_CTL_READ_BIT   = 0;
    localparam int DEE_STA_DONE_BIT   = 0;

    // Array geometry: 1K bytes, ten index bits
    localparam int DEE_DEPTH   = 1024;
    localparam int DEE_IDX_W   = 10;
    localparam int DEE_HIGH_W  = 2;

    // Reset values
    localparam logic [7:0] DEE_RST_BYTE = 8'h00;
    localparam logic       DEE_RST_BIT  = 1'b0;

    // Unlock keys
    localparam logic [7:0] DEE_KEY_FIRST  = 8'h55;
    localparam logic [7:0] DEE_KEY_SECOND = 8'haa;

    // Timing: write cycle time in microseconds at the bus clock rate
    localparam int DEE_CLK_HZ        = 40_000_000;
    localparam int DEE_WRITE_TIME_US = 4000;
    localparam int DEE_WRITE_CYCLES  = DEE_WRITE_TIME_US * (DEE_CLK_HZ / 1_000_000);
    localparam int DEE_WAIT_W        = 18;

    // One register write as handed from the bus slave to the core
    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } dee_wr_t;

    // Progress through the two-key unlock sequence
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_ARMED
    } dee_key_t;

    // True for an offset that has a register behind it
    function automatic logic dee_mapped(input logic [7:0] addr);
        dee_mapped = (addr == DEE_OFF_INDEX_LOW) || (addr == DEE_OFF_INDEX_HIGH) ||
                     (addr == DEE_OFF_BUFFER)    || (addr == DEE_OFF_CONTROL)    ||
                     (addr == DEE_OFF_KEY_PORT)  || (addr == DEE_OFF_STATUS)     ||
                     (addr == DEE_OFF_MASK);
    endfunction : dee_mapped

endpackage : dee_pkg

// ### core/dee_mem.sv
`timescale 1ns/1ps
// Byte array with one port; read data always comes from a register
module dee_mem
    import dee_pkg::*;
(
    input  wire logic                 hclk,   // Bus clock
    input  wire logic                 we,     // Write strobe
    input  wire logic [DEE_IDX_W-1:0] addr,   // Byte index
    input  wire logic [7:0]           wdata,  // Byte to store
    output logic      [7:0]           rdata   // Byte at addr, one edge late
);

    logic [7:0] cells [DEE_DEPTH];

    // No reset on the array: contents survive like the real cells would
    always_ff @(posedge hclk)
    begin
        if (we)
        begin
            cells[addr] <= wdata;
        end
        rdata <= cells[addr];
    end

endmodule : dee_mem

// ### core/dee_ahb.sv
`timescale 1ns/1ps
// AHB-Lite slave front end: one write cycle, reads with one wait state
module dee_ahb
    import dee_pkg::*;
(
    input  wire logic        hclk,      // Bus clock
    input  wire logic        hresetn,   // Async reset, active low
    input  wire logic        hsel,      // Slave select
    input  wire logic [31:0] haddr,     // Address
    input  wire logic [1:0]  htrans,    // Transfer type
    input  wire logic        hwrite,    // Write when high
    input  wire logic [2:0]  hsize,     // Word only
    input  wire logic [31:0] hwdata,    // Write data
    input  wire logic        hready,    // Bus ready
    output logic             hreadyout, // Slave ready
    output logic             hresp,     // Always OKAY
    output logic      [31:0] hrdata,    // Read data
    output dee_wr_t          wr,        // Write handed to the core
    output logic      [7:0]  rd_addr,   // Offset being read
    input  wire logic [31:0] rd_data    // Core read-back word
);

    typedef struct packed {
        logic [7:0]  addr;
        logic        pend_wr;
        logic        pend_rd;
        logic [31:0] rdata;
    } dee_ahb_state_t;

    dee_ahb_state_t s;
    dee_ahb_state_t next_s;
    logic           take;

    // Only single word transfers are expected; hsize is accepted as given
    assign take = hsel && htrans[1] && hready;

    always_comb
    begin
        next_s         = s;
        next_s.pend_wr = 1'b0;
        if (s.pend_rd)
        begin
            // Sample one edge after the previous write has landed
            next_s.rdata   = dee_mapped(s.addr) ? rd_data : 32'h0000_0000;
            next_s.pend_rd = 1'b0;
        end
        if (take)
        begin
            next_s.addr    = {haddr[7:2], 2'b00};
            next_s.pend_wr = hwrite;
            next_s.pend_rd = !hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Unmapped writes are dropped here so the core never sees them
    assign wr.valid   = s.pend_wr && dee_mapped(s.addr);
    assign wr.addr    = s.addr;
    assign wr.wdata   = hwdata;
    assign rd_addr    = s.addr;
    assign hreadyout  = !s.pend_rd;
    assign hresp      = 1'b0;
    assign hrdata     = s.rdata;

endmodule : dee_ahb

// ### testbench/dee_monitor.sv
`timescale 1ns/1ps
// Bus handshake and interrupt relations watched at the controller pins
module dee_monitor
    import dee_pkg::*;
(
    input wire logic        hclk,      // Bus clock
    input wire logic        hresetn,   // Async reset, active low
    input wire logic        hsel,      // Slave select
    input wire logic [1:0]  htrans,    // Transfer type
    input wire logic        hwrite,    // Write when high
    input wire logic        hready,    // Bus ready
    input wire logic        hreadyout, // Slave ready
    input wire logic        hresp,     // Response
    input wire logic [31:0] hrdata,    // Read data
    input wire logic        irq        // Level interrupt
);
    logic taken;
    logic rd_dp;
    logic wr_dp;

    assign taken = hsel && htrans[1] && hready;

    // Track which kind of data phase is open; a stalled phase stays open
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_dp <= 1'b0;
            wr_dp <= 1'b0;
        end
        else if (hready)
        begin
            rd_dp <= taken && !hwrite;
            wr_dp <= taken && hwrite;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_OKAY_ONLY: assert property (hresp == 1'b0)
        else $error("slave gave a non OKAY response");
    AST_ONE_WAIT: assert property (!hreadyout |=> hreadyout)
        else $error("wait state lasted more than one cycle");
    AST_READ_WAITS: assert property ((taken && !hwrite) |=> !hreadyout)
        else $error("read data phase had no wait state");
    AST_WRITE_NO_WAIT: assert property ((taken && hwrite) |=> hreadyout)
        else $error("write data phase was stretched");
    AST_WAIT_ONLY_READ: assert property (!hreadyout |-> rd_dp)
        else $error("wait state outside a read");
    AST_RDATA_HOLD: assert property (!$stable(hrdata) |-> (rd_dp || $past(rd_dp)))
        else $error("read data changed outside a read");
    AST_IRQ_SW_CLEAR: assert property ($fell(irq) |-> $past(wr_dp && hreadyout))
        else $error("interrupt dropped without a register write");
    AST_RESET_STATE: assert property ($rose(hresetn) |-> hreadyout && !irq && hrdata == 32'h0)
        else $error("outputs not idle after reset");
endmodule : dee_monitor

// ### testbench/test_data_eeprom_access_ctrl.sv
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module test_data_eeprom_access_ctrl
    import dee_pkg::*;
;
    localparam int WC = 40; // Short byte write keeps the run brief

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [31:0] rdv;
    int          failures;
    int          checks;

    dee_ctrl #(.WRITE_CYCLES(WC)) dee_ctrl_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

    // Free running bus clock, 25 ns
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Single word transfer; the address phase is held until hready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        `CHK(n, e, q);
    endtask : rd_chk

    task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
        wr(DEE_OFF_KEY_PORT, 32'(k1));
        wr(DEE_OFF_KEY_PORT, 32'(k2));
    endtask : keys

    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge hclk);
        failures++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        haddr   = 32'h0;
        hwdata  = 32'h0;
        failures = 0;
        checks   = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values of every register, then the unmapped slot
        for (int i = 0; i < 8; i++)
            rd_chk("reset value", 8'(i * 4), 32'h0);
        wr(8'h1c, 32'hffffffff);
        rd_chk("unmapped", 8'h1c, 32'h0);
        wr(DEE_OFF_INDEX_HIGH, 32'hff);
        rd_chk("index high", DEE_OFF_INDEX_HIGH, 32'h3);
        wr(DEE_OFF_INDEX_LOW, 32'h7e);
        wr(DEE_OFF_BUFFER, 32'h5a);
        rd_chk("buffer", DEE_OFF_BUFFER, 32'h5a);
        wr(DEE_OFF_MASK, 32'h1);
        // Go refused without permit, and with permit in the same write
        keys(DEE_KEY_FIRST, DEE_KEY_SECOND);
        wr(DEE_OFF_CONTROL, 32'h02);
        rd_chk("go no permit", DEE_OFF_CONTROL, 32'h00);
        keys(DEE_KEY_FIRST, DEE_KEY_SECOND);
        wr(DEE_OFF_CONTROL, 32'h06);
        rd_chk("go with permit", DEE_OFF_CONTROL, 32'h04);
        // Broken unlock orders start nothing
        keys(DEE_KEY_SECOND, DEE_KEY_FIRST);
        wr(DEE_OFF_CONTROL, 32'h06);
        rd_chk("swapped keys", DEE_OFF_CONTROL, 32'h04);
        wr(DEE_OFF_KEY_PORT, 32'(DEE_KEY_FIRST));
        wr(DEE_OFF_INDEX_HIGH, 32'h2);
        wr(DEE_OFF_KEY_PORT, 32'(DEE_KEY_SECOND));
        wr(DEE_OFF_CONTROL, 32'h06);
        rd_chk("split keys", DEE_OFF_CONTROL, 32'h04);
        rd_chk("no done", DEE_OFF_STATUS, 32'h0);
        // Proper write, with registers frozen while it runs
        keys(DEE_KEY_FIRST, DEE_KEY_SECOND);
        wr(DEE_OFF_CONTROL, 32'h06);
        rd_chk("write running", DEE_OFF_CONTROL, 32'h06);
        wr(DEE_OFF_INDEX_LOW, 32'h11);
        wr(DEE_OFF_BUFFER, 32'h33);
        wr(DEE_OFF_CONTROL, 32'h00);
        rd_chk("frozen low", DEE_OFF_INDEX_LOW, 32'h7e);
        rd_chk("frozen buffer", DEE_OFF_BUFFER, 32'h5a);
        rd_chk("frozen control", DEE_OFF_CONTROL, 32'h06);
        rdv = 32'h0;
        for (int i = 0; i < 30 && rdv[0] !== 1'b1; i++)
            xfer(1'b0, DEE_OFF_STATUS, 32'h0, rdv);
        `CHK("done flag", 1'b1, rdv[0]);
        rd_chk("go cleared", DEE_OFF_CONTROL, 32'h04);
        wr(DEE_OFF_CONTROL, 32'h00);
        rd_chk("permit cleared", DEE_OFF_CONTROL, 32'h00);
        `CHK("irq unmasked", 1'b1, irq);
        // Mask hides the flag; only a W1C clears it
        wr(DEE_OFF_MASK, 32'h0);
        rd_chk("flag kept", DEE_OFF_STATUS, 32'h1);
        `CHK("irq masked", 1'b0, irq);
        wr(DEE_OFF_MASK, 32'h1);
        rd_chk("mask", DEE_OFF_MASK, 32'h1);
        `CHK("irq again", 1'b1, irq);
        wr(DEE_OFF_STATUS, 32'h1);
        rd_chk("flag cleared", DEE_OFF_STATUS, 32'h0);
        `CHK("irq cleared", 1'b0, irq);
        // Read back the stored byte; one transfer sits between start and fetch
        wr(DEE_OFF_BUFFER, 32'h00);
        wr(DEE_OFF_CONTROL, 32'h01);
        rd_chk("read start self clear", DEE_OFF_CONTROL, 32'h00);
        rd_chk("fetched byte", DEE_OFF_BUFFER, 32'h5a);
        wr(DEE_OFF_INDEX_LOW, 32'h00);
        rd_chk("byte held", DEE_OFF_BUFFER, 32'h5a);
        // Program space selected: the read fetches nothing
        wr(DEE_OFF_BUFFER, 32'h99);
        wr(DEE_OFF_CONTROL, 32'h81);
        rd_chk("space select", DEE_OFF_CONTROL, 32'h80);
        rd_chk("buffer untouched", DEE_OFF_BUFFER, 32'h99);
        give_verdict();
    end
endmodule : test_data_eeprom_access_ctrl

bind dee_ctrl dee_monitor dee_monitor_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
